// file: pkg/sen_pkg.sv
/*
 * Constants, types and access classes for the state-enable-0 gate.
 * Assumes a single hart clock and a 32-bit register bus.
 */
package sen_pkg;

	// Gate bit positions in the state-enable-0 layout
	localparam int BIT_VENDOR = 0;
	localparam int BIT_FCSR   = 1;
	localparam int BIT_JVT    = 2;
	localparam int BIT_QOS    = 55;
	localparam int BIT_P113   = 56;
	localparam int BIT_DBG    = 57;
	localparam int BIT_IFILE  = 58;
	localparam int BIT_ADV    = 59;
	localparam int BIT_IND    = 60;
	localparam int BIT_RSV    = 61;
	localparam int BIT_ENV    = 62;
	localparam int BIT_SUB    = 63;

	// Bits that can hold a one at each level, and the reset value
	localparam logic [63:0] M_WR_MASK = 64'hdf80_0000_0000_0007;
	localparam logic [63:0] H_WR_MASK = 64'hde00_0000_0000_0007;
	localparam logic [63:0] S_WR_MASK = 64'h0000_0000_0000_0007;
	localparam logic [63:0] RST_VAL   = 64'h0000_0000_0000_0000;

	// Register byte offsets
	localparam logic [4:0] OFS_M_LO = 5'h00;
	localparam logic [4:0] OFS_M_HI = 5'h04;
	localparam logic [4:0] OFS_H_LO = 5'h08;
	localparam logic [4:0] OFS_H_HI = 5'h0c;
	localparam logic [4:0] OFS_S_LO = 5'h10;
	localparam logic [4:0] OFS_S_VS = 5'h14;
	localparam logic [4:0] OFS_STAT = 5'h18;

	// Privilege encodings
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;

	typedef enum logic [3:0] {
		CLS_VENDOR, CLS_FP, CLS_JVT, CLS_SSTATE, CLS_HSTATE, CLS_SENV, CLS_HENV,
		CLS_IND_REG, CLS_IFILE, CLS_ADV_IRQ, CLS_SCTX, CLS_HCTX, CLS_HDELEG, CLS_QOS
	} sen_cls_t;

	typedef struct packed {
		logic       valid;
		sen_cls_t   cls;
		logic [1:0] priv;
		logic       virt;
	} sen_req_t;

	typedef struct packed {
		logic done;
		logic illegal;
		logic virtual_trap;
	} sen_rsp_t;

endpackage

// file: rtl/sen_gate.sv
/*
 * State-enable-0 register bank for machine, hypervisor and supervisor
 * levels, a permit-or-trap decision for gated accesses and a byte-lane helper.
 * Assumes an Avalon-MM master on the hart clock, and that the core
 * presents access checks from logic on the same clock.
 */
`timescale 1ns/10ps

// Notes on behaviour
// - Bit 0 gates all custom state; the bit itself is standard.
// - Setting bit 0 changes nothing for purely standard software.
// - Bit 1 gates fcsr when float ops use integer registers.
// - With misa.F set, bit 1 reads zero at every level.
// - Without misa.F and bit 1 clear, float instructions below machine mode trap.
// - Bit 2 gates the jump-table CSR.
// - Bit 63 gates lower stateen CSRs; hypervisor copy gates supervisor one.
// - Bit 62 gates environment CSRs; hypervisor copy gates senvcfg only.
// - Bit 60 gates indirect select and alias CSRs, guest view too.
// - Bit 58 gates interrupt-file state, guest copy gates guest file.
// - Clear hypervisor bit 58 blocks guest file like a zero guest index.
// - Bit 59 gates remaining advanced-interrupt state at both levels.
// - Bit 57 gates debug context CSRs; hypervisor copy gates scontext only.
// - Machine gate bit guards hedelegh.
// - Machine gate bit guards srmcfg.
// - Bit 61 and reserved positions have no function.
// - Reset clears every writable machine enable bit.
// - Blocked access raises illegal, or virtual when only the hypervisor copy blocks a guest mode.
// - Machine zero bits read zero in lower registers.
// - Hypervisor zero bits read zero in supervisor view from VS.
// - Reserved and unimplemented bits read zero.
module sen_gate
	import sen_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Hart configuration
	input  wire logic        misa_f,
	// Access check
	input  wire sen_req_t    chk_req,
	output sen_rsp_t         chk_rsp,
	// Guest interrupt-file reach
	output logic             guest_ifile_blocked
);

	// Stored enable bits, latest check outcome and trap count
	logic [63:0] m_reg;
	logic [63:0] h_reg;
	logic [63:0] s_reg;
	logic        last_illegal;
	logic        last_virtual;
	logic [15:0] trap_count;

	// Effective (read) views
	wire  [63:0] fcsr_mask;
	wire  [63:0] m_eff;
	wire  [63:0] h_eff;
	wire  [63:0] s_eff;
	wire  [63:0] s_vs;

	// Float state lives in f registers when misa.F is set
	assign fcsr_mask = misa_f ? ~(64'h1 << BIT_FCSR) : ~64'h0;
	assign m_eff = m_reg & M_WR_MASK & fcsr_mask;
	assign h_eff = h_reg & H_WR_MASK & m_eff;
	assign s_eff = s_reg & S_WR_MASK & m_eff;
	assign s_vs  = s_eff & h_eff;

	// Bus decode
	wire         bus_req;
	wire         bus_take;
	wire         sel_m_lo;
	wire         sel_m_hi;
	wire         sel_h_lo;
	wire         sel_h_hi;
	wire         sel_s_lo;
	wire         sel_s_vs;
	wire         sel_stat;
	wire  [31:0] stat_word;
	wire  [31:0] rd_mux;

	assign bus_req  = avs_read | avs_write;
	assign bus_take = avs_write & ~avs_waitrequest;
	assign sel_m_lo = (avs_address == OFS_M_LO);
	assign sel_m_hi = (avs_address == OFS_M_HI);
	assign sel_h_lo = (avs_address == OFS_H_LO);
	assign sel_h_hi = (avs_address == OFS_H_HI);
	assign sel_s_lo = (avs_address == OFS_S_LO);
	assign sel_s_vs = (avs_address == OFS_S_VS);
	assign sel_stat = (avs_address == OFS_STAT);
	assign stat_word = {trap_count, 12'h000, last_virtual, last_illegal,
		guest_ifile_blocked, misa_f};

	// Unmapped words read as zero and ignore writes
	assign rd_mux = sel_m_lo ? m_eff[31:0] :
		sel_m_hi ? m_eff[63:32] :
		sel_h_lo ? h_eff[31:0] :
		sel_h_hi ? h_eff[63:32] :
		sel_s_lo ? s_eff[31:0] :
		sel_s_vs ? s_vs[31:0] :
		sel_stat ? stat_word : 32'h0000_0000;

	// Byte-lane merge of a write into one half
	wire  [31:0] m_lo_new;
	wire  [31:0] m_hi_new;
	wire  [31:0] h_lo_new;
	wire  [31:0] h_hi_new;
	wire  [31:0] s_lo_new;

	sen_lane_merge u_m_lo (
		.old_word (m_reg[31:0]),
		.wr_data  (avs_writedata),
		.lane_en  (avs_byteenable),
		.new_word (m_lo_new)
	);

	sen_lane_merge u_m_hi (
		.old_word (m_reg[63:32]),
		.wr_data  (avs_writedata),
		.lane_en  (avs_byteenable),
		.new_word (m_hi_new)
	);

	sen_lane_merge u_h_lo (
		.old_word (h_reg[31:0]),
		.wr_data  (avs_writedata),
		.lane_en  (avs_byteenable),
		.new_word (h_lo_new)
	);

	sen_lane_merge u_h_hi (
		.old_word (h_reg[63:32]),
		.wr_data  (avs_writedata),
		.lane_en  (avs_byteenable),
		.new_word (h_hi_new)
	);

	sen_lane_merge u_s_lo (
		.old_word (s_reg[31:0]),
		.wr_data  (avs_writedata),
		.lane_en  (avs_byteenable),
		.new_word (s_lo_new)
	);

	// Write strobes, one per writable word, and the read capture strobe
	wire         wr_m_lo;
	wire         wr_m_hi;
	wire         wr_h_lo;
	wire         wr_h_hi;
	wire         wr_s_lo;
	wire         rd_capture;

	assign wr_m_lo    = bus_take & sel_m_lo;
	assign wr_m_hi    = bus_take & sel_m_hi;
	assign wr_h_lo    = bus_take & sel_h_lo;
	assign wr_h_hi    = bus_take & sel_h_hi;
	assign wr_s_lo    = bus_take & sel_s_lo;
	assign rd_capture = avs_read & avs_waitrequest;

	// Next register values; only writable bits are ever stored
	wire  [63:0] next_m;
	wire  [63:0] next_h;
	wire  [63:0] next_s;

	// Lower copies keep masked bits, so re-enabling a machine bit restores them
	assign next_m = M_WR_MASK & (
		wr_m_lo ? {m_reg[63:32], m_lo_new} :
		wr_m_hi ? {m_hi_new, m_reg[31:0]} : m_reg);
	assign next_h = H_WR_MASK & (
		wr_h_lo ? {h_reg[63:32], h_lo_new} :
		wr_h_hi ? {h_hi_new, h_reg[31:0]} : h_reg);
	// Upper half of the supervisor register is always zero
	assign next_s = S_WR_MASK & (
		wr_s_lo ? {32'h0000_0000, s_lo_new} : s_reg);

	// One wait state per access: waitrequest drops for a single cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
		end
	end

	// Captured on the request cycle, so the data stands with the answer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_capture) begin
			avs_readdata <= rd_mux;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			m_reg <= RST_VAL;
			h_reg <= RST_VAL;
			s_reg <= RST_VAL;
		end else begin
			m_reg <= next_m;
			h_reg <= next_h;
			s_reg <= next_s;
		end
	end

	// Class decode: gate bit, hypervisor layer, user layer
	logic [5:0]  cls_bit;
	logic        cls_h;
	logic        cls_u;

	always_comb begin
		cls_bit = 6'(BIT_VENDOR);
		cls_h   = 1'b1;
		cls_u   = 1'b1;
		case (chk_req.cls)
			CLS_VENDOR: begin
				cls_bit = 6'(BIT_VENDOR);
			end
			CLS_FP: begin
				cls_bit = 6'(BIT_FCSR);
			end
			CLS_JVT: begin
				cls_bit = 6'(BIT_JVT);
			end
			CLS_SSTATE: begin
				cls_bit = 6'(BIT_SUB);
				cls_u   = 1'b0;
			end
			CLS_HSTATE: begin
				cls_bit = 6'(BIT_SUB);
				cls_h   = 1'b0;
				cls_u   = 1'b0;
			end
			CLS_SENV: begin
				cls_bit = 6'(BIT_ENV);
				cls_u   = 1'b0;
			end
			CLS_HENV: begin
				cls_bit = 6'(BIT_ENV);
				cls_h   = 1'b0;
				cls_u   = 1'b0;
			end
			CLS_IND_REG: begin
				cls_bit = 6'(BIT_IND);
				cls_u   = 1'b0;
			end
			CLS_IFILE: begin
				cls_bit = 6'(BIT_IFILE);
				cls_u   = 1'b0;
			end
			CLS_ADV_IRQ: begin
				cls_bit = 6'(BIT_ADV);
				cls_u   = 1'b0;
			end
			CLS_SCTX: begin
				cls_bit = 6'(BIT_DBG);
				cls_u   = 1'b0;
			end
			CLS_HCTX: begin
				cls_bit = 6'(BIT_DBG);
				cls_h   = 1'b0;
				cls_u   = 1'b0;
			end
			CLS_HDELEG: begin
				cls_bit = 6'(BIT_P113);
				cls_h   = 1'b0;
				cls_u   = 1'b0;
			end
			CLS_QOS: begin
				cls_bit = 6'(BIT_QOS);
				cls_h   = 1'b0;
				cls_u   = 1'b0;
			end
			default: begin
				cls_bit = 6'(BIT_VENDOR);
			end
		endcase
	end

	// Decision terms
	wire         is_m;
	wire         is_user;
	wire         fp_free;
	wire         m_ok;
	wire         h_ok;
	wire         u_ok;
	wire         deny_ill;
	wire         deny_virt;

	assign is_m    = (chk_req.priv == PRIV_M);
	assign is_user = (chk_req.priv == PRIV_U);
	// Float ops on f registers are not gated here
	assign fp_free = (chk_req.cls == CLS_FP) & misa_f;
	assign m_ok    = m_eff[cls_bit];
	assign h_ok    = ~cls_h | h_eff[cls_bit];
	// Guest user mode sees the supervisor bits through the guest mask
	assign u_ok    = ~cls_u | (chk_req.virt ? s_vs[cls_bit] : s_eff[cls_bit]);

	// Machine denial outranks the guest layer; user layer comes last
	assign deny_ill = ~is_m & ~fp_free & (~m_ok |
		(is_user & h_ok & ~u_ok));
	assign deny_virt = ~is_m & ~fp_free & m_ok & chk_req.virt &
		~h_ok;

	// Registered answer, one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			chk_rsp <= '0;
		end else begin
			chk_rsp.done         <= chk_req.valid;
			chk_rsp.illegal      <= chk_req.valid & deny_ill;
			chk_rsp.virtual_trap <= chk_req.valid & deny_virt;
		end
	end

	// Outcome of the latest check, for status reads
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			last_illegal <= 1'b0;
			last_virtual <= 1'b0;
		end else if (chk_req.valid) begin
			last_illegal <= deny_ill;
			last_virtual <= deny_virt;
		end
	end

	// Wraps silently; software takes differences between two reads
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			trap_count <= 16'h0000;
		end else if (chk_req.valid & (deny_ill | deny_virt)) begin
			trap_count <= trap_count + 16'h0001;
		end
	end

	// Same effect as a zero guest interrupt-file index
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			guest_ifile_blocked <= 1'b1;
		end else begin
			guest_ifile_blocked <= ~h_eff[BIT_IFILE];
		end
	end

endmodule

// Byte-lane merge; a disabled lane keeps the stored byte
module sen_lane_merge
#(
	parameter int LANES = 4
)
(
	// Stored word and bus data
	input  wire logic [8*LANES-1:0] old_word,
	input  wire logic [8*LANES-1:0] wr_data,
	// Lane enables, one per byte
	input  wire logic [LANES-1:0]   lane_en,
	// Merged word
	output logic      [8*LANES-1:0] new_word
);

	// Lanes are independent, so a partial write never disturbs a neighbour
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		assign new_word[8*g +: 8] = lane_en[g] ? wr_data[8*g +: 8] : old_word[8*g +: 8];
	end

endmodule

// file: verification/sen_gate_chk.sv
/* Port checker for sen_gate.
   Bound to sen_gate from the testbench top file. */
`timescale 1ns/10ps
module sen_gate_chk
	import sen_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Register bus
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Hart and checks
	input wire logic        misa_f,
	input wire sen_req_t    chk_req,
	input wire sen_rsp_t    chk_rsp,
	input wire logic        guest_ifile_blocked
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic rd_ack = !avs_waitrequest && avs_read;
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
	property p_ack; s_req |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_done; chk_req.valid |=> chk_rsp.done; endproperty
	a_done: assert property (p_done) else $error("check not answered");
	property p_idle; !chk_req.valid |=> !chk_rsp.done; endproperty
	a_idle: assert property (p_idle) else $error("spurious done");
	property p_qual; !chk_rsp.done |-> !chk_rsp.illegal && !chk_rsp.virtual_trap; endproperty
	a_qual: assert property (p_qual) else $error("trap without done");
	property p_one; chk_rsp.illegal |-> !chk_rsp.virtual_trap; endproperty
	a_one: assert property (p_one) else $error("two traps");
	property p_mach; chk_req.valid && chk_req.priv == PRIV_M |=> chk_rsp == 3'b100; endproperty
	a_mach: assert property (p_mach) else $error("machine mode trapped");
	property p_fp; chk_req.valid && chk_req.cls == CLS_FP && misa_f |=> chk_rsp == 3'b100;
	endproperty
	a_fp: assert property (p_fp) else $error("fp trapped with misa f");
	property p_nvirt; chk_req.valid && !chk_req.virt |=> !chk_rsp.virtual_trap; endproperty
	a_nvirt: assert property (p_nvirt) else $error("virtual trap from host");
	property p_fpbit; rd_ack && misa_f && $past(misa_f) && avs_address[4:3] != 2'h3
		&& !avs_address[2] |-> !avs_readdata[1]; endproperty
	a_fpbit: assert property (p_fpbit) else $error("fcsr gate reads one");
	property p_rsv; rd_ack && (avs_address == OFS_M_HI || avs_address == OFS_H_HI)
		|-> avs_readdata[29] == 1'b0 && avs_readdata[22:0] == 23'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
endmodule

// file: verification/tb_top.sv
/* Self-checking bench for sen_gate.
   Drives the Avalon bus and the check port directly. */
`timescale 1ns/10ps
module tb_top
	import sen_pkg::*;
;
	logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, misa_f, gib;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0]  avs_byteenable;
	sen_req_t    chk_req;
	sen_rsp_t    chk_rsp;
	int          n_mismatch, cmp_count;

	sen_gate u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .misa_f(misa_f), .chk_req(chk_req),
		.chk_rsp(chk_rsp), .guest_ifile_blocked(gib));

	initial begin
		clk_sys = 0;
		forever #2 clk_sys = ~clk_sys;
	end

	task print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	// Extra idle edge first, so a release never meets a new request
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (i == 20) begin
			n_mismatch++;
			print_verdict();
		end
	endtask

	task wr(input logic [4:0] a, input logic [31:0] d);
		bus(1, a, d);
	endtask

	task rd(input logic [4:0] a, input logic [31:0] e);
		bus(0, a, 0);
		cmp($sformatf("reg %h", a), e, q);
	endtask

	task ck(input sen_cls_t c, input logic [1:0] p, input logic v, input logic [1:0] e);
		@(posedge clk_sys);
		chk_req <= '{1'b1, c, p, v};
		@(posedge clk_sys);
		chk_req.valid <= 1'b0;
		@(posedge clk_sys);
		cmp("check", {29'h0, 1'b1, e}, {29'h0, chk_rsp});
	endtask

	initial begin
		{rst_n, avs_read, avs_write, misa_f, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		chk_req = '0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1;
		rd(OFS_M_LO, 0);
		rd(OFS_M_HI, 0);
		rd(OFS_STAT, 32'h2);
		wr(5'h1c, '1);
		rd(5'h1c, 0);
		$display("test reset done");
		wr(OFS_H_LO, 0);
		wr(OFS_H_HI, 0);
		wr(OFS_S_LO, 0);
		wr(OFS_M_LO, '1);
		wr(OFS_M_HI, '1);
		rd(OFS_M_LO, 32'h7);
		rd(OFS_M_HI, 32'hdf80_0000);
		wr(OFS_H_LO, '1);
		wr(OFS_H_HI, '1);
		wr(OFS_S_LO, '1);
		rd(OFS_H_HI, 32'hde00_0000);
		rd(OFS_S_LO, 32'h7);
		cmp("ifile", 0, {31'h0, gib});
		misa_f <= 1;
		rd(OFS_M_LO, 32'h5);
		rd(OFS_S_LO, 32'h5);
		misa_f <= 0;
		wr(OFS_M_LO, 0);
		rd(OFS_H_LO, 0);
		rd(OFS_S_LO, 0);
		wr(OFS_M_LO, 32'h7);
		rd(OFS_H_LO, 32'h7);
		wr(OFS_H_LO, 32'h1);
		rd(OFS_S_VS, 32'h1);
		wr(OFS_H_HI, 0);
		rd(OFS_H_HI, 0);
		cmp("ifile", 1, {31'h0, gib});
		$display("test registers done");
		ck(CLS_VENDOR, PRIV_S, 1, 2'b00);
		ck(CLS_JVT, PRIV_S, 1, 2'b01);
		ck(CLS_JVT, PRIV_S, 0, 2'b00);
		ck(CLS_SSTATE, PRIV_S, 1, 2'b01);
		ck(CLS_IFILE, PRIV_S, 1, 2'b01);
		ck(CLS_HSTATE, PRIV_S, 1, 2'b00);
		ck(CLS_FP, PRIV_U, 0, 2'b00);
		wr(OFS_S_LO, 0);
		ck(CLS_VENDOR, PRIV_U, 0, 2'b10);
		wr(OFS_M_HI, 0);
		ck(CLS_SENV, PRIV_S, 0, 2'b10);
		ck(CLS_QOS, PRIV_S, 0, 2'b10);
		ck(CLS_HCTX, PRIV_M, 0, 2'b00);
		wr(OFS_M_LO, 0);
		ck(CLS_FP, PRIV_S, 0, 2'b10);
		misa_f <= 1;
		ck(CLS_FP, PRIV_U, 1, 2'b00);
		misa_f <= 0;
		rd(OFS_STAT, 32'h0007_0002);
		$display("test checks done");
		avs_byteenable <= 4'h8;
		wr(OFS_M_HI, '1);
		avs_byteenable <= 4'hf;
		rd(OFS_M_HI, 32'hdf00_0000);
		wr(OFS_M_LO, 32'h7);
		rst_n <= 0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1;
		rd(OFS_M_LO, 0);
		rd(OFS_M_HI, 0);
		rd(OFS_STAT, 32'h2);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule

bind sen_gate sen_gate_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .misa_f(misa_f),
	.chk_req(chk_req), .chk_rsp(chk_rsp), .guest_ifile_blocked(guest_ifile_blocked));
